// ### src/sck_divider.sv
`timescale 1ns/1ps
`include "sync_serial_defines.svh"

// ****************************************************************
// divider for the internal serial clock, one tick per half period
// ****************************************************************
module sck_divider #(
  parameter int DIV_W = `SST_DIV_W
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic clear_in,
  input wire logic [2:0] sel_in,
  output logic tick_out
);
  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;
  logic [DIV_W-1:0] limit;

  always_comb
  begin
    limit = DIV_W'((`SST_SCK_HALF_BASE << sel_in) - 1'b1);
    tick_out = !clear_in && (cnt_r >= limit);
    cnt_nxt = cnt_r + 1'b1;
    // clearing keeps the first half period full length
    if (clear_in || tick_out)
    begin
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ### src/sync_serial_defines.svh
`ifndef SYNC_SERIAL_DEFINES_SVH
`define SYNC_SERIAL_DEFINES_SVH

// ****************************************************************
// timing
// ****************************************************************
`define SST_CLK_PERIOD_NS 50
// least serial clock cycle in two-wire mode, kept by software
`define SST_MIN_SCK_NS 2000
`define SST_MIN_SCK_CYC \
  ((`SST_MIN_SCK_NS + `SST_CLK_PERIOD_NS - 1) / `SST_CLK_PERIOD_NS)
`define SST_DIV_W 12
// half serial period for select 0, doubled per select step
`define SST_SCK_HALF_BASE 12'h0002

// ****************************************************************
// word and tail shape
// ****************************************************************
`define SST_CNT_W 5
`define SST_LAST_8 5'h07
`define SST_LAST_16 5'h0F
`define SST_UNIT_W 2
`define SST_HOLD_LOW 2'h1
`define SST_HOLD_LAST 2'h1
`define SST_LATCH_LOW 2'h2
`define SST_LATCH_LAST 2'h2

`endif

// ### src/sync_serial_pkg.sv
package sync_serial_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_TAIL} xfer_state_t;
endpackage

// ### src/sync_serial_tail_mark.sv
// Operation
// RULE_01: control write with tail off reinitialises state
// RULE_02: lower mode bit picks 8 or 16 bits
// RULE_03: host loads low byte, or both bytes
// RULE_04: start write begins shifting out and in
// RULE_05: last bit sets the completion request flag
// RULE_06: internal clock pulses only during a word
// RULE_07: idle data output holds the last bit
// RULE_08: idle external clock edges set overrun, no shift
// RULE_09: idle level write drives data output at once
// RULE_10: host reads low byte, or both bytes
// RULE_11: transmit and receive share the same edges
// RULE_12: two-wire mode appends hold or latch tail
// RULE_13: host uses internal clock of two microseconds
// RULE_14: tail timing unit is the serial period
// RULE_15: word end clears start, sets done, then tail
// RULE_16: host changes tail enable only when idle
// RULE_17: host presets level high and open drain
// RULE_18: completion interrupt gated by its enable
// RULE_19: external clock only after start is set
// RULE_20: host waits on interrupt or polled flag
// RULE_21: host routes the pins to the serial function
// RULE_22: drive on falling edge, sample on rising, lsb first
// RULE_23: overrun clears by zero write after reading one
// RULE_24: start reads one while busy, zero write ignored
// RULE_25: bit counter ends word after 8 or 16 bits
`timescale 1ns/1ps
`include "sync_serial_defines.svh"

module sync_serial_tail_mark (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic standby_in,
  input wire logic ctrl_wr_in,
  input wire logic mode_upper_bit_in,
  input wire logic mode_lower_bit_in,
  input wire logic tail_enable_in,
  input wire logic latch_variant_select_in,
  input wire logic clock_ext_in,
  input wire logic [2:0] clock_select_field_in,
  input wire logic start_wr_in,
  input wire logic level_wr_in,
  input wire logic level_val_in,
  input wire logic status_rd_in,
  input wire logic overrun_clr_in,
  input wire logic done_clr_in,
  input wire logic transfer_irq_enable_in,
  input wire logic data_low_wr_in,
  input wire logic data_high_wr_in,
  input wire logic [7:0] data_wr_in,
  input wire logic serial_in_pin_in,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_out,
  output logic serial_out_pin_out,
  output logic [7:0] data_low_out,
  output logic [7:0] data_high_out,
  output logic start_flag_out,
  output logic transfer_done_request_out,
  output logic overrun_flag_out,
  output logic tail_in_progress_out,
  output logic output_level_out,
  output logic irq_out
);
  sync_serial_pkg::xfer_state_t state_r, state_nxt;
  logic sck_r, sck_nxt, so_r, so_nxt, start_r, start_nxt;
  logic done_r, done_nxt, ovr_r, ovr_nxt, seen_r, seen_nxt;
  logic half_r, half_nxt, pin_prev_r;
  logic upper_r, upper_nxt, wide_r, wide_nxt, tail_en_r, tail_en_nxt;
  logic latch_r, latch_nxt, ext_r, ext_nxt;
  logic [2:0] sel_r, sel_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic [`SST_CNT_W-1:0] cnt_r, cnt_nxt, last;
  logic [`SST_UNIT_W-1:0] unit_r, unit_nxt, tail_low, tail_last;
  logic tick, fall, rise, ext_fall, ext_rise, word_end, div_clear;

  // ****************************************************************
  // internal serial clock
  // ****************************************************************
  assign div_clear = (state_r == sync_serial_pkg::ST_IDLE) || ext_r;

  sck_divider #(
    .DIV_W(`SST_DIV_W)
  ) u_div (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(div_clear),
    .sel_in(sel_r), // [RULE_14]
    .tick_out(tick)
  );

  // ****************************************************************
  // transfer engine
  // ****************************************************************
  always_comb
  begin
    state_nxt = state_r;
    sck_nxt = sck_r;
    so_nxt = so_r; // [RULE_07]
    start_nxt = start_r;
    done_nxt = done_r;
    ovr_nxt = ovr_r;
    seen_nxt = seen_r;
    half_nxt = half_r;
    upper_nxt = upper_r;
    wide_nxt = wide_r;
    tail_en_nxt = tail_en_r;
    latch_nxt = latch_r;
    ext_nxt = ext_r;
    sel_nxt = sel_r;
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    unit_nxt = unit_r;
    word_end = 1'b0;
    last = wide_r ? `SST_LAST_16 : `SST_LAST_8; // [RULE_02]
    tail_low = latch_r ? `SST_LATCH_LOW : `SST_HOLD_LOW;
    tail_last = latch_r ? `SST_LATCH_LAST : `SST_HOLD_LAST;
    ext_fall = ext_r && pin_prev_r && !serial_clock_pin_in;
    ext_rise = ext_r && !pin_prev_r && serial_clock_pin_in;
    fall = ext_r ? ext_fall : (tick && sck_r);
    rise = ext_r ? ext_rise : (tick && !sck_r);
    if (done_clr_in)
    begin
      done_nxt = 1'b0;
    end
    if (status_rd_in && ovr_r)
    begin
      seen_nxt = 1'b1;
    end
    if (overrun_clr_in && seen_r)
    begin
      ovr_nxt = 1'b0; // [RULE_23]
      seen_nxt = 1'b0;
    end
    if (data_low_wr_in)
    begin
      shift_nxt[7:0] = data_wr_in;
    end
    if (data_high_wr_in)
    begin
      shift_nxt[15:8] = data_wr_in;
    end
    case (state_r)
      sync_serial_pkg::ST_IDLE:
      begin
        sck_nxt = 1'b1; // [RULE_06]
        if (level_wr_in)
        begin
          so_nxt = level_val_in; // [RULE_09]
        end
        // stray clock while idle: flag it, never shift on it
        if (ext_fall)
        begin
          ovr_nxt = 1'b1; // [RULE_08]
        end
        if (start_wr_in)
        begin
          start_nxt = 1'b1; // [RULE_04] [RULE_24]
          cnt_nxt = '0;
          state_nxt = sync_serial_pkg::ST_XFER;
        end
      end
      sync_serial_pkg::ST_XFER:
      begin
        if (!ext_r && tick)
        begin
          sck_nxt = !sck_r; // [RULE_06]
        end
        if (fall)
        begin
          so_nxt = shift_r[0]; // [RULE_22]
        end
        if (rise)
        begin
          // receive shifts in from the top on the rising edge
          if (wide_r)
          begin
            shift_nxt = {serial_in_pin_in, shift_r[15:1]}; // [RULE_11]
          end
          else
          begin
            shift_nxt = {shift_r[15:8], serial_in_pin_in, shift_r[7:1]};
          end
          cnt_nxt = cnt_r + 1'b1; // [RULE_25]
          if (cnt_r == last)
          begin
            word_end = 1'b1;
            start_nxt = 1'b0; // [RULE_15]
            done_nxt = 1'b1; // [RULE_05]
            unit_nxt = '0;
            half_nxt = 1'b0;
            state_nxt = tail_en_r ? sync_serial_pkg::ST_TAIL
                                  : sync_serial_pkg::ST_IDLE; // [RULE_12]
          end
        end
      end
      sync_serial_pkg::ST_TAIL:
      begin
        sck_nxt = 1'b1;
        so_nxt = (unit_r < tail_low) ? 1'b0 : 1'b1; // [RULE_12]
        if (tick)
        begin
          half_nxt = !half_r;
          if (half_r)
          begin
            unit_nxt = unit_r + 1'b1; // [RULE_14]
            if (unit_r == tail_last)
            begin
              state_nxt = sync_serial_pkg::ST_IDLE;
            end
          end
        end
      end
      default:
      begin
        state_nxt = sync_serial_pkg::ST_IDLE;
      end
    endcase
    if (ctrl_wr_in)
    begin
      upper_nxt = mode_upper_bit_in;
      wide_nxt = mode_lower_bit_in;
      tail_en_nxt = tail_enable_in;
      latch_nxt = latch_variant_select_in;
      ext_nxt = clock_ext_in;
      sel_nxt = clock_select_field_in;
      if (!tail_enable_in)
      begin
        state_nxt = sync_serial_pkg::ST_IDLE; // [RULE_01]
        cnt_nxt = '0;
        start_nxt = 1'b0;
        sck_nxt = 1'b1;
        half_nxt = 1'b0;
        unit_nxt = '0;
      end
    end
    // module standby acts as a synchronous reset of the whole unit
    if (standby_in)
    begin
      state_nxt = sync_serial_pkg::ST_IDLE;
      {sck_nxt, so_nxt, start_nxt, done_nxt, ovr_nxt, seen_nxt} = 6'h20;
      {upper_nxt, wide_nxt, tail_en_nxt, latch_nxt, ext_nxt} = '0;
      sel_nxt = '0;
      shift_nxt = '0;
      cnt_nxt = '0;
      unit_nxt = '0;
      half_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_r <= sync_serial_pkg::ST_IDLE;
      {sck_r, so_r, start_r, done_r, ovr_r, seen_r} <= 6'h20;
      {upper_r, wide_r, tail_en_r, latch_r, ext_r} <= '0;
      {half_r, pin_prev_r} <= 2'h0;
      sel_r <= '0;
      shift_r <= '0;
      cnt_r <= '0;
      unit_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      {sck_r, so_r, start_r, done_r, ovr_r, seen_r} <=
        {sck_nxt, so_nxt, start_nxt, done_nxt, ovr_nxt, seen_nxt};
      {upper_r, wide_r, tail_en_r, latch_r, ext_r} <=
        {upper_nxt, wide_nxt, tail_en_nxt, latch_nxt, ext_nxt};
      {half_r, pin_prev_r} <= {half_nxt, serial_clock_pin_in};
      sel_r <= sel_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      unit_r <= unit_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign serial_clock_pin_out = sck_r;
  assign serial_clock_pin_oe_out = !ext_r;
  assign serial_out_pin_out = so_r;
  assign output_level_out = so_r;
  assign data_low_out = shift_r[7:0];
  assign data_high_out = shift_r[15:8];
  assign start_flag_out = start_r;
  assign transfer_done_request_out = done_r;
  assign overrun_flag_out = ovr_r;
  assign tail_in_progress_out = (state_r == sync_serial_pkg::ST_TAIL);
  assign irq_out = done_r && transfer_irq_enable_in; // [RULE_18]

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  init_state_a: assert property (ctrl_wr_in && !tail_enable_in
    && !standby_in |=> state_r == sync_serial_pkg::ST_IDLE
    && cnt_r == '0 && !start_r) // [RULE_01]
    else $error("control write did not reinitialise");
  start_begin_a: assert property (start_wr_in && !ctrl_wr_in
    && !standby_in && state_r == sync_serial_pkg::ST_IDLE
    |=> start_r && state_r == sync_serial_pkg::ST_XFER) // [RULE_04]
    else $error("start write did not begin transfer");
  word_done_a: assert property (word_end && !ctrl_wr_in && !standby_in
    |=> done_r && !start_r) // [RULE_15]
    else $error("word end did not raise done and drop start");
  word_count_a: assert property (word_end |-> cnt_r ==
    (wide_r ? `SST_LAST_16 : `SST_LAST_8)) // [RULE_25]
    else $error("word ended at wrong bit count");
  tail_follow_a: assert property (word_end && tail_en_r && !ctrl_wr_in
    && !standby_in |=> tail_in_progress_out) // [RULE_12]
    else $error("tail did not follow word");
  idle_clock_a: assert property (state_r == sync_serial_pkg::ST_IDLE
    && $past(state_r == sync_serial_pkg::ST_IDLE) |-> sck_r) // [RULE_06]
    else $error("clock pulsed while idle");
  idle_hold_a: assert property (state_r == sync_serial_pkg::ST_IDLE
    && !level_wr_in && !standby_in |=> $stable(so_r)) // [RULE_07]
    else $error("idle data output changed");
  level_write_a: assert property (level_wr_in && !standby_in
    && state_r == sync_serial_pkg::ST_IDLE
    |=> so_r == $past(level_val_in)) // [RULE_09]
    else $error("level write not driven");
  overrun_set_a: assert property (ext_fall && !standby_in // [RULE_08]
    && !data_low_wr_in && !data_high_wr_in
    && state_r == sync_serial_pkg::ST_IDLE
    |=> ovr_r && $stable(shift_r))
    else $error("stray clock not flagged");
  overrun_keep_a: assert property (ovr_r && !seen_r && !standby_in
    |=> ovr_r) // [RULE_23]
    else $error("overrun cleared without prior read");
  irq_gate_a: assert property ( // [RULE_18]
    !transfer_irq_enable_in |-> !irq_out)
    else $error("interrupt passed while disabled");
endmodule

// ### verif/serial_peer.sv
`timescale 1ns/1ps
// ****************************************
// far-side serial peripheral
// ****************************************
module serial_peer (
  input wire logic clk_in,
  input wire logic pin_sck_in,
  input wire logic sout_in,
  input wire logic arm_in,
  input wire logic [15:0] tx_in,
  input wire logic [4:0] ext_n_in,
  input wire logic ext_go_in,
  output logic sin_out,
  output logic ext_sck_out,
  output logic [15:0] rx_out,
  output logic [15:0] rises_out,
  output logic [15:0] per_out
);
  logic sck_q = 1'b1;
  logic [15:0] t = 16'h0000;
  logic [15:0] last_t = 16'h0000;
  initial
  begin
    sin_out = 1'b0;
    ext_sck_out = 1'b1;
    rx_out = 16'h0000;
    rises_out = 16'h0000;
    per_out = 16'h0000;
  end
  always @(posedge clk_in)
  begin
    sck_q <= pin_sck_in;
    t <= t + 16'h0001;
    if (arm_in === 1'b0)
    begin
      rises_out <= 16'h0000;
      // out of frame the line shows nothing stable
      sin_out <= ~sin_out;
    end
    else if (pin_sck_in === 1'b1 && sck_q === 1'b0)
    begin
      rx_out <= {sout_in, rx_out[15:1]};
      rises_out <= rises_out + 16'h0001;
      per_out <= t - last_t;
      last_t <= t;
    end
    else if (pin_sck_in === 1'b0 && sck_q === 1'b1)
      sin_out <= tx_in[rises_out[3:0]];
  end
  // clock stands high, pulses ext_n times each time ext_go rises
  always @(posedge ext_go_in)
  begin
    repeat (ext_n_in)
    begin
      repeat (4) @(posedge clk_in);
      ext_sck_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      ext_sck_out <= 1'b1;
    end
  end
endmodule

// ### verif/sync_serial_tail_mark_tb.sv
`timescale 1ns/1ps
module sync_serial_tail_mark_tb;
  typedef struct packed {
    logic l16;
    logic [2:0] sel;
    logic [15:0] tx;
    logic [15:0] rx;
  } row_t;
  logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, standby_in = 1'b0;
  logic ctrl_wr_in = 1'b0, mode_upper_bit_in = 1'b0;
  logic mode_lower_bit_in = 1'b0, tail_enable_in = 1'b0;
  logic latch_variant_select_in = 1'b0, clock_ext_in = 1'b0;
  logic [2:0] clock_select_field_in = 3'h0;
  logic start_wr_in = 1'b0, level_wr_in = 1'b0, level_val_in = 1'b0;
  logic status_rd_in = 1'b0, overrun_clr_in = 1'b0, done_clr_in = 1'b0;
  logic transfer_irq_enable_in = 1'b0, data_low_wr_in = 1'b0;
  logic data_high_wr_in = 1'b0;
  logic [7:0] data_wr_in = 8'h00;
  logic serial_in_pin_in, serial_clock_pin_in, ext_sck;
  logic serial_clock_pin_out, serial_clock_pin_oe_out, serial_out_pin_out;
  logic [7:0] data_low_out, data_high_out;
  logic start_flag_out, transfer_done_request_out, overrun_flag_out;
  logic tail_in_progress_out, output_level_out, irq_out;
  logic arm = 1'b0, ext_go = 1'b0;
  logic [4:0] ext_n = 5'h08;
  logic [15:0] peer_tx = 16'h0000;
  logic [15:0] rx_seen, rises, per;
  int n_fail = 0;
  int n_tests = 0;
  int n, t_len, t_low, t_sck, ex;
  row_t rows[4] = '{
    '{1'b0, 3'h0, 16'h00A5, 16'h003C},
    '{1'b1, 3'h1, 16'hC3A6, 16'h5A17},
    '{1'b0, 3'h2, 16'h0041, 16'h00E2},
    '{1'b1, 3'h0, 16'h8001, 16'h7FFE}};
  // pins routed to the serial function for the whole run
  assign serial_clock_pin_in =
    serial_clock_pin_oe_out ? serial_clock_pin_out : ext_sck;
  sync_serial_tail_mark DUT (.clk_sys_in, .sys_rst_in, .standby_in,
    .ctrl_wr_in, .mode_upper_bit_in, .mode_lower_bit_in, .tail_enable_in,
    .latch_variant_select_in, .clock_ext_in, .clock_select_field_in,
    .start_wr_in, .level_wr_in, .level_val_in, .status_rd_in,
    .overrun_clr_in, .done_clr_in, .transfer_irq_enable_in,
    .data_low_wr_in, .data_high_wr_in, .data_wr_in, .serial_in_pin_in,
    .serial_clock_pin_in, .serial_clock_pin_out, .serial_clock_pin_oe_out,
    .serial_out_pin_out, .data_low_out, .data_high_out, .start_flag_out,
    .transfer_done_request_out, .overrun_flag_out, .tail_in_progress_out,
    .output_level_out, .irq_out);
  serial_peer peer (.clk_in(clk_sys_in), .pin_sck_in(serial_clock_pin_in),
    .sout_in(serial_out_pin_out), .arm_in(arm), .tx_in(peer_tx),
    .ext_n_in(ext_n), .ext_go_in(ext_go), .sin_out(serial_in_pin_in),
    .ext_sck_out(ext_sck), .rx_out(rx_seen), .rises_out(rises),
    .per_out(per));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys_in);
  endtask
  task automatic cfg(input logic l16, tl, lt, xc, input logic [2:0] s);
    ctrl_wr_in = 1'b1;
    mode_lower_bit_in = l16;
    tail_enable_in = tl;
    latch_variant_select_in = lt;
    clock_ext_in = xc;
    clock_select_field_in = s;
    tick(1);
    ctrl_wr_in = 1'b0;
    tick(1);
  endtask
  task automatic load_go(input logic [15:0] w);
    data_low_wr_in = 1'b1;
    data_wr_in = w[7:0];
    tick(1);
    data_low_wr_in = 1'b0;
    data_high_wr_in = 1'b1;
    data_wr_in = w[15:8];
    tick(1);
    data_high_wr_in = 1'b0;
    start_wr_in = 1'b1;
    tick(1);
    start_wr_in = 1'b0;
  endtask
  task automatic lvl(input logic v);
    level_wr_in = 1'b1;
    level_val_in = v;
    tick(1);
    level_wr_in = 1'b0;
    tick(2);
    chk("level_out", 16'(v), 16'(serial_out_pin_out));
  endtask
  // polled with the interrupt off in rows 0 and 2, bounded
  task automatic wait_done();
    n = 0;
    while (transfer_done_request_out !== 1'b1 && n < 5000)
    begin
      tick(1);
      n++;
    end
    if (n == 5000)
    begin
      n_fail++;
      final_report();
    end
  endtask
  task automatic clr_done();
    done_clr_in = 1'b1;
    tick(1);
    done_clr_in = 1'b0;
    tick(1);
  endtask
  task automatic ext_pulses(input logic [4:0] k);
    ext_n = k;
    ext_go = 1'b1;
    tick(1);
    ext_go = 1'b0;
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  initial
  begin
    tick(2);
    sys_rst_in = 1'b0;
    tick(1);
    chk("rst_sck", 16'h0001, 16'(serial_clock_pin_out));
    chk("rst_start", 16'h0000, 16'(start_flag_out));
    foreach (rows[i])
    begin
      cfg(rows[i].l16, 1'b0, 1'b0, 1'b0, rows[i].sel);
      transfer_irq_enable_in = i[0];
      peer_tx = rows[i].rx;
      arm = 1'b1;
      load_go(rows[i].tx);
      tick(1);
      chk("busy_start", 16'h0001, 16'(start_flag_out));
      wait_done();
      chk("end_start", 16'h0000, 16'(start_flag_out));
      chk("irq", 16'(i[0]), 16'(irq_out));
      tick(12 << rows[i].sel);
      chk("rises", rows[i].l16 ? 16'h0010 : 16'h0008, rises);
      chk("period", 16'(4 << rows[i].sel), per);
      chk("tx", rows[i].l16 ? rows[i].tx : 16'(rows[i].tx[7:0]),
        rows[i].l16 ? rx_seen : 16'(rx_seen[15:8]));
      chk("rx_lo", 16'(rows[i].rx[7:0]), 16'(data_low_out));
      if (rows[i].l16)
        chk("rx_hi", 16'(rows[i].rx[15:8]), 16'(data_high_out));
      chk("hold", 16'(rows[i].l16 ? rows[i].tx[15] : rows[i].tx[7]),
        16'(serial_out_pin_out));
      arm = 1'b0;
      clr_done();
      $display("row %0d finished", i);
    end
    arm = 1'b1;
    cfg(1'b1, 1'b0, 1'b0, 1'b0, 3'h2);
    load_go(16'h1234);
    tick(20);
    cfg(1'b1, 1'b0, 1'b0, 1'b0, 3'h2);
    chk("abort_start", 16'h0000, 16'(start_flag_out));
    tick(2);
    n = rises;
    tick(64);
    chk("abort_quiet", 16'(n), rises);
    chk("abort_done", 16'h0000, 16'(transfer_done_request_out));
    // peer bit index restarts only while disarmed
    arm = 1'b0;
    tick(1);
    lvl(1'b1);
    lvl(1'b0);
    $display("abort and level finished");
    cfg(1'b0, 1'b0, 1'b0, 1'b1, 3'h0);
    peer_tx = 16'h0069;
    arm = 1'b1;
    load_go(16'h00D2);
    ext_pulses(5'h08);
    wait_done();
    tick(16);
    chk("ext_rx", 16'h0069, 16'(data_low_out));
    chk("ext_tx", 16'h00D2, 16'(rx_seen[15:8]));
    arm = 1'b0;
    ext_pulses(5'h01);
    tick(16);
    chk("overrun", 16'h0001, 16'(overrun_flag_out));
    chk("no_shift", 16'h0069, 16'(data_low_out));
    overrun_clr_in = 1'b1;
    tick(1);
    overrun_clr_in = 1'b0;
    tick(2);
    chk("ovr_kept", 16'h0001, 16'(overrun_flag_out));
    status_rd_in = 1'b1;
    tick(1);
    status_rd_in = 1'b0;
    overrun_clr_in = 1'b1;
    tick(1);
    overrun_clr_in = 1'b0;
    tick(2);
    chk("ovr_clear", 16'h0000, 16'(overrun_flag_out));
    clr_done();
    $display("external clock finished");
    lvl(1'b1);
    for (int lt = 0; lt < 2; lt++)
    begin
      // select 4 keeps the serial period above two microseconds
      cfg(1'b0, 1'b1, lt[0], 1'b0, 3'h4);
      load_go(16'h0096);
      wait_done();
      chk("tail_start", 16'h0000, 16'(start_flag_out));
      chk("tail_flag", 16'h0001, 16'(tail_in_progress_out));
      t_len = 0;
      t_low = 0;
      t_sck = 0;
      while (tail_in_progress_out === 1'b1 && t_len < 1000)
      begin
        t_len++;
        t_low += (serial_out_pin_out === 1'b0);
        t_sck += (serial_clock_pin_out === 1'b0);
        tick(1);
      end
      ex = (lt + 2) * 64;
      chk("tail_len", 16'h0001,
        16'(t_len >= ex - 2 && t_len <= ex + 2));
      ex = (lt + 1) * 64;
      chk("tail_low", 16'h0001,
        16'(t_low >= ex - 2 && t_low <= ex + 2));
      chk("tail_sck", 16'h0000, 16'(t_sck));
      clr_done();
      $display("tail variant %0d finished", lt);
    end
    final_report();
  end
endmodule
